// File: rtl/rx_control_pkg.sv
// Package: receive-control register map, field layout and frame constants
package rx_control_pkg;

	// Register byte addresses on APB
	localparam logic [11:0] ADDR_RECEIVE_CONTROL = 12'h100;
	localparam logic [11:0] ADDR_RX_STATUS = 12'h104;
	localparam logic [31:0] RECEIVE_CONTROL_RESET = 32'h0000_0000;
	// Writable bits: long-frame enable plus bits 8..30 less reserved 14 and 24
	localparam logic [31:0] RECEIVE_CONTROL_WMASK = 32'h7eff_bf20;

	// Field positions inside receive_control
	localparam int LONG_FRAME_ENABLE_BIT = 5;
	localparam int FREE_DESC_THRESHOLD_LO = 8;
	localparam int DESCRIPTOR_FORMAT_LO = 10;
	localparam int MCAST_HASH_OFFSET_LO = 12;
	localparam int BROADCAST_ACCEPT_BIT = 15;
	localparam int RX_BUFFER_SIZE_LO = 16;
	localparam int VLAN_TABLE_ENABLE_BIT = 18;
	localparam int CANONICAL_CHECK_BIT = 19;
	localparam int CANONICAL_VALUE_BIT = 20;
	localparam int DISCARD_PAUSE_BIT = 22;
	localparam int PASS_CONTROL_BIT = 23;
	localparam int BUFFER_SIZE_EXT_BIT = 25;
	localparam int STRIP_CRC_BIT = 26;
	localparam int FLEX_BUFFER_LO = 27;

	// Field encodings
	localparam logic [1:0] THRESHOLD_HALF = 2'h0;
	localparam logic [1:0] THRESHOLD_QUARTER = 2'h1;
	localparam logic [1:0] THRESHOLD_EIGHTH = 2'h2;
	localparam logic [1:0] DESC_LEGACY = 2'h0;
	localparam logic [1:0] DESC_PACKET_SPLIT = 2'h1;

	// Buffer sizes in bytes
	localparam logic [15:0] BUF_2048 = 16'h0800;
	localparam logic [15:0] BUF_1024 = 16'h0400;
	localparam logic [15:0] BUF_512 = 16'h0200;
	localparam logic [15:0] BUF_256 = 16'h0100;
	localparam logic [15:0] BUF_16384 = 16'h4000;
	localparam logic [15:0] BUF_8192 = 16'h2000;
	localparam logic [15:0] BUF_4096 = 16'h1000;
	localparam logic [15:0] BUF_RESERVED = 16'h0000;

	// Frame constants
	localparam logic [15:0] LONG_FRAME_BYTES = 16'h05f2;
	localparam logic [15:0] CRC_BYTES = 16'h0004;
	localparam logic [15:0] ETHERTYPE_MAC_CONTROL = 16'h8808;
	localparam logic [15:0] OPCODE_PAUSE = 16'h0001;
	localparam logic [47:0] MAC_CONTROL_MCAST = 48'h0180_c200_0001;
	localparam logic [47:0] BROADCAST_ADDR = 48'hffff_ffff_ffff;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_FRAME = 2'b10
	} frame_state_type;

endpackage

// File: rtl/rx_frame_decide.sv
// Per-frame acceptance, buffer sizing and hash index from a config snapshot
`timescale 1ns/1ns
`default_nettype none
module rx_frame_decide (
	input wire logic [31:0] cfg_in,
	input wire logic [47:0] dest_addr_in,
	input wire logic filter_match_in,
	input wire logic station_match_in,
	input wire logic vlan_tagged_in,
	input wire logic vlan_table_hit_in,
	input wire logic cfi_in,
	input wire logic [15:0] ethertype_in,
	input wire logic [15:0] opcode_in,
	input wire logic [15:0] frame_len_in,
	input wire logic [15:0] psplit_buf_bytes_in,
	output logic accept_out,
	output logic [15:0] buf_bytes_out,
	output logic [15:0] desc_len_out,
	output logic [11:0] hash_index_out
);

	function automatic logic [15:0] rx_buffer_size_code_bytes(input logic [1:0] code, input logic ext);
		logic [15:0] b;
		b = rx_control_pkg::BUF_RESERVED;
		case ({ext, code})
			3'h0: b = rx_control_pkg::BUF_2048;
			3'h1: b = rx_control_pkg::BUF_1024;
			3'h2: b = rx_control_pkg::BUF_512;
			3'h3: b = rx_control_pkg::BUF_256;
			3'h5: b = rx_control_pkg::BUF_16384;
			3'h6: b = rx_control_pkg::BUF_8192;
			3'h7: b = rx_control_pkg::BUF_4096;
			default: b = rx_control_pkg::BUF_RESERVED;
		endcase
		return b;
	endfunction

	logic is_ctrl_type;
	logic is_pause;
	logic ctrl_addressed;
	logic is_bcast;
	logic [3:0] flex_kb;

	always_comb begin
		flex_kb = cfg_in[rx_control_pkg::FLEX_BUFFER_LO +: 4];
		is_bcast = (dest_addr_in == rx_control_pkg::BROADCAST_ADDR);
		is_ctrl_type = (ethertype_in == rx_control_pkg::ETHERTYPE_MAC_CONTROL);
		is_pause = is_ctrl_type && (opcode_in == rx_control_pkg::OPCODE_PAUSE);
		ctrl_addressed = station_match_in ||
			(dest_addr_in == rx_control_pkg::MAC_CONTROL_MCAST);

		// Address decision first, then the non-pause control-frame override, then each veto in turn
		accept_out = filter_match_in ||
			(is_bcast && cfg_in[rx_control_pkg::BROADCAST_ACCEPT_BIT]);
		if (is_pause) begin
			if (station_match_in && cfg_in[rx_control_pkg::DISCARD_PAUSE_BIT]) begin
				accept_out = 1'b0;
			end
		end else if (is_ctrl_type) begin
			accept_out = ctrl_addressed && cfg_in[rx_control_pkg::PASS_CONTROL_BIT];
		end
		if (vlan_tagged_in) begin
			if (cfg_in[rx_control_pkg::VLAN_TABLE_ENABLE_BIT] && !vlan_table_hit_in) begin
				accept_out = 1'b0;
			end
			if (cfg_in[rx_control_pkg::CANONICAL_CHECK_BIT] &&
				(cfi_in != cfg_in[rx_control_pkg::CANONICAL_VALUE_BIT])) begin
				accept_out = 1'b0;
			end
		end
		if (!cfg_in[rx_control_pkg::LONG_FRAME_ENABLE_BIT] &&
			(frame_len_in > rx_control_pkg::LONG_FRAME_BYTES)) begin
			accept_out = 1'b0;
		end

		// Flexible size wins, then descriptor format, then the coded size
		if (flex_kb != 4'h0) begin
			buf_bytes_out = {2'b00, flex_kb, 10'h000};
		end else if (cfg_in[rx_control_pkg::DESCRIPTOR_FORMAT_LO +: 2] ==
			rx_control_pkg::DESC_PACKET_SPLIT) begin
			buf_bytes_out = psplit_buf_bytes_in;
		end else if (cfg_in[rx_control_pkg::DESCRIPTOR_FORMAT_LO +: 2] ==
			rx_control_pkg::DESC_LEGACY) begin
			buf_bytes_out = rx_buffer_size_code_bytes(cfg_in[rx_control_pkg::RX_BUFFER_SIZE_LO +: 2],
				cfg_in[rx_control_pkg::BUFFER_SIZE_EXT_BIT]);
		end else begin
			buf_bytes_out = rx_control_pkg::BUF_RESERVED;
		end

		// Descriptor length drops the CRC when it is stripped
		if (cfg_in[rx_control_pkg::STRIP_CRC_BIT] && (frame_len_in >= rx_control_pkg::CRC_BYTES)) begin
			desc_len_out = frame_len_in - rx_control_pkg::CRC_BYTES;
		end else begin
			desc_len_out = frame_len_in;
		end

		case (cfg_in[rx_control_pkg::MCAST_HASH_OFFSET_LO +: 2])
			2'h0: hash_index_out = dest_addr_in[47:36];
			2'h1: hash_index_out = dest_addr_in[46:35];
			2'h2: hash_index_out = dest_addr_in[45:34];
			default: hash_index_out = dest_addr_in[43:32];
		endcase
	end

endmodule // rx_frame_decide
`default_nettype wire

// File: rtl/rx_control_filter_config.sv
// Receive-control register, per-frame decision latch and descriptor threshold event
`timescale 1ns/1ns
`default_nettype none

module rx_control_filter_config (
	input wire logic CLK_IN,
	input wire logic RESET_N_IN,
	// APB slave
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [11:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	// Receive path, core clock
	input wire logic FRAME_START_IN,
	input wire logic FRAME_END_IN,
	input wire logic [47:0] DEST_ADDR_IN,
	input wire logic FILTER_MATCH_IN,
	input wire logic STATION_MATCH_IN,
	input wire logic VLAN_TAGGED_IN,
	input wire logic VLAN_TABLE_HIT_IN,
	input wire logic CFI_IN,
	input wire logic [15:0] ETHERTYPE_IN,
	input wire logic [15:0] OPCODE_IN,
	input wire logic [15:0] FRAME_LEN_IN,
	input wire logic [15:0] PSPLIT_BUF_BYTES_IN,
	// Descriptor ring status
	input wire logic [15:0] RING_DESC_COUNT_IN,
	input wire logic [15:0] FREE_DESC_COUNT_IN,
	// Frame verdict and descriptor threshold event
	output logic VERDICT_VALID_OUT,
	output logic ACCEPT_OUT,
	output logic [15:0] BUF_BYTES_OUT,
	output logic [15:0] DESC_LEN_OUT,
	output logic [11:0] HASH_INDEX_OUT,
	output logic STRIP_CRC_OUT,
	output logic [1:0] DESCRIPTOR_FORMAT_OUT,
	output logic FREE_DESC_THRESHOLD_OUT
);

	typedef struct packed {
		rx_control_pkg::frame_state_type st;
		logic [31:0] receive_control;
		logic [31:0] snap;
		logic [31:0] prdata;
		logic slverr;
		logic verdict_valid;
		logic accept;
		logic [15:0] buf_bytes;
		logic [15:0] desc_len;
		logic [11:0] hash_index;
		logic thr_equal;
		logic thr_event;
		logic [7:0] accept_count;
		logic [7:0] drop_count;
	} ctl_state_type;

	ctl_state_type state_ff;
	ctl_state_type nxt_state;

	logic [31:0] eval_cfg;
	logic dec_accept;
	logic [15:0] dec_buf_bytes;
	logic [15:0] dec_desc_len;
	logic [11:0] dec_hash;
	logic [15:0] thr_count;
	logic thr_valid;
	logic setup_phase;
	logic access_phase;
	logic addr_ctl;
	logic addr_status;
	logic [31:0] status_word;

	// A frame that starts and ends in one cycle sees the live register
	assign eval_cfg = FRAME_START_IN ? state_ff.receive_control : state_ff.snap;

	rx_frame_decide u_decide (
		.cfg_in(eval_cfg),
		.dest_addr_in(DEST_ADDR_IN),
		.filter_match_in(FILTER_MATCH_IN),
		.station_match_in(STATION_MATCH_IN),
		.vlan_tagged_in(VLAN_TAGGED_IN),
		.vlan_table_hit_in(VLAN_TABLE_HIT_IN),
		.cfi_in(CFI_IN),
		.ethertype_in(ETHERTYPE_IN),
		.opcode_in(OPCODE_IN),
		.frame_len_in(FRAME_LEN_IN),
		.psplit_buf_bytes_in(PSPLIT_BUF_BYTES_IN),
		.accept_out(dec_accept),
		.buf_bytes_out(dec_buf_bytes),
		.desc_len_out(dec_desc_len),
		.hash_index_out(dec_hash)
	);

	always_comb begin
		setup_phase = PSEL_IN && !PENABLE_IN;
		access_phase = PSEL_IN && PENABLE_IN;
		addr_ctl = (PADDR_IN == rx_control_pkg::ADDR_RECEIVE_CONTROL);
		addr_status = (PADDR_IN == rx_control_pkg::ADDR_RX_STATUS);
		status_word = {8'h00, state_ff.drop_count, state_ff.accept_count,
			4'h0, state_ff.st == rx_control_pkg::ST_FRAME, state_ff.thr_equal,
			state_ff.verdict_valid, state_ff.accept};

		// Threshold is the ring size shifted by the selected fraction
		thr_valid = 1'b1;
		case (state_ff.receive_control[rx_control_pkg::FREE_DESC_THRESHOLD_LO +: 2])
			rx_control_pkg::THRESHOLD_HALF: thr_count = {1'b0, RING_DESC_COUNT_IN[15:1]};
			rx_control_pkg::THRESHOLD_QUARTER: thr_count = {2'b00, RING_DESC_COUNT_IN[15:2]};
			rx_control_pkg::THRESHOLD_EIGHTH: thr_count = {3'b000, RING_DESC_COUNT_IN[15:3]};
			default: begin
				thr_count = 16'h0000;
				thr_valid = 1'b0;
			end
		endcase
	end

	always_comb begin
		nxt_state = state_ff;
		nxt_state.verdict_valid = 1'b0;
		nxt_state.thr_event = 1'b0;

		// Read data and error are captured in setup so they come from flops
		if (setup_phase) begin
			nxt_state.slverr = !(addr_ctl || addr_status);
			if (PWRITE_IN) begin
				nxt_state.prdata = 32'h0000_0000;
			end else if (addr_ctl) begin
				nxt_state.prdata = state_ff.receive_control;
			end else if (addr_status) begin
				nxt_state.prdata = status_word;
			end else begin
				nxt_state.prdata = 32'h0000_0000;
			end
		end

		// Write lands at the access edge; reserved bits stay zero
		if (access_phase && PWRITE_IN && addr_ctl) begin
			nxt_state.receive_control = PWDATA_IN & rx_control_pkg::RECEIVE_CONTROL_WMASK;
		end

		case (state_ff.st)
			rx_control_pkg::ST_IDLE: begin
				if (FRAME_START_IN) begin
					// One-cycle frame must still leave its settings on the level outputs
					nxt_state.snap = state_ff.receive_control;
					if (!FRAME_END_IN) begin
						nxt_state.st = rx_control_pkg::ST_FRAME;
					end
				end
			end
			rx_control_pkg::ST_FRAME: begin
				if (FRAME_START_IN) begin
					// Restart drops the unfinished frame's context
					nxt_state.snap = state_ff.receive_control;
				end
				if (FRAME_END_IN) begin
					nxt_state.st = rx_control_pkg::ST_IDLE;
				end
			end
			default: begin
				nxt_state.st = rx_control_pkg::ST_IDLE;
			end
		endcase

		if (FRAME_END_IN) begin
			nxt_state.verdict_valid = 1'b1;
			nxt_state.accept = dec_accept;
			nxt_state.buf_bytes = dec_buf_bytes;
			nxt_state.desc_len = dec_desc_len;
			nxt_state.hash_index = dec_hash;
			if (dec_accept) begin
				nxt_state.accept_count = state_ff.accept_count + 8'h01;
			end else begin
				nxt_state.drop_count = state_ff.drop_count + 8'h01;
			end
		end

		// Event only on the cycle the free count becomes equal
		nxt_state.thr_equal = thr_valid && (RING_DESC_COUNT_IN != 16'h0000) &&
			(FREE_DESC_COUNT_IN == thr_count);
		nxt_state.thr_event = nxt_state.thr_equal && !state_ff.thr_equal;
	end

	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			state_ff <= '{
				st: rx_control_pkg::ST_IDLE,
				receive_control: rx_control_pkg::RECEIVE_CONTROL_RESET,
				snap: rx_control_pkg::RECEIVE_CONTROL_RESET,
				prdata: 32'h0000_0000,
				slverr: 1'b0,
				verdict_valid: 1'b0,
				accept: 1'b0,
				buf_bytes: 16'h0000,
				desc_len: 16'h0000,
				hash_index: 12'h000,
				thr_equal: 1'b0,
				thr_event: 1'b0,
				accept_count: 8'h00,
				drop_count: 8'h00
			};
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Zero-wait slave: every transfer completes in its first access cycle
	assign PREADY_OUT = 1'b1;
	assign PRDATA_OUT = state_ff.prdata;
	assign PSLVERR_OUT = state_ff.slverr && PSEL_IN && PENABLE_IN;
	assign VERDICT_VALID_OUT = state_ff.verdict_valid;
	assign ACCEPT_OUT = state_ff.accept;
	assign BUF_BYTES_OUT = state_ff.buf_bytes;
	assign DESC_LEN_OUT = state_ff.desc_len;
	assign HASH_INDEX_OUT = state_ff.hash_index;
	// Strip happens upstream of the checksum engine, so the level is per frame
	assign STRIP_CRC_OUT = state_ff.snap[rx_control_pkg::STRIP_CRC_BIT];
	assign DESCRIPTOR_FORMAT_OUT = state_ff.snap[rx_control_pkg::DESCRIPTOR_FORMAT_LO +: 2];
	assign FREE_DESC_THRESHOLD_OUT = state_ff.thr_event;

endmodule // rx_control_filter_config
`default_nettype wire

// File: verif/rx_cfg_properties.sv
// Checker: verdict timing, length, sizing, threshold pulse and APB answer
`timescale 1ns/1ns
`default_nettype none
module rx_cfg_properties (
	input wire logic CLK_IN,
	input wire logic RESET_N_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic [11:0] PADDR_IN,
	input wire logic PREADY_OUT,
	input wire logic PSLVERR_OUT,
	input wire logic FRAME_END_IN,
	input wire logic [15:0] FRAME_LEN_IN,
	input wire logic [15:0] PSPLIT_BUF_BYTES_IN,
	input wire logic [15:0] RING_DESC_COUNT_IN,
	input wire logic [15:0] FREE_DESC_COUNT_IN,
	input wire logic VERDICT_VALID_OUT,
	input wire logic [15:0] BUF_BYTES_OUT,
	input wire logic [15:0] DESC_LEN_OUT,
	input wire logic STRIP_CRC_OUT,
	input wire logic [1:0] DESCRIPTOR_FORMAT_OUT,
	input wire logic FREE_DESC_THRESHOLD_OUT
);
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (!RESET_N_IN);
	logic eq;
	logic vv;
	// Any fraction counts: the code itself is not visible at the ports
	assign eq = RING_DESC_COUNT_IN != 16'h0000 && (FREE_DESC_COUNT_IN == RING_DESC_COUNT_IN >> 1
		|| FREE_DESC_COUNT_IN == RING_DESC_COUNT_IN >> 2
		|| FREE_DESC_COUNT_IN == RING_DESC_COUNT_IN >> 3);
	assign vv = VERDICT_VALID_OUT;
	a_thresh_cause: assert property (FREE_DESC_THRESHOLD_OUT |-> $past(eq))
		else $error("threshold pulse without equal count");
	a_thresh_pulse: assert property (FREE_DESC_THRESHOLD_OUT |=> !FREE_DESC_THRESHOLD_OUT)
		else $error("threshold pulse longer than one cycle");
	a_verdict_after: assert property (FRAME_END_IN |=> vv)
		else $error("no verdict after frame end");
	a_verdict_cause: assert property (vv |-> $past(FRAME_END_IN))
		else $error("verdict without frame end");
	a_strip_len: assert property (vv && STRIP_CRC_OUT |->
		DESC_LEN_OUT == $past(FRAME_LEN_IN) - 16'h0004)
		else $error("stripped length wrong");
	a_full_len: assert property (vv && !STRIP_CRC_OUT |-> DESC_LEN_OUT == $past(FRAME_LEN_IN))
		else $error("unstripped length wrong");
	a_split_size: assert property (vv && DESCRIPTOR_FORMAT_OUT == 2'h1 |->
		BUF_BYTES_OUT == $past(PSPLIT_BUF_BYTES_IN))
		else $error("split buffer size wrong");
	a_fmt_reserved: assert property (vv && DESCRIPTOR_FORMAT_OUT[1] |->
		BUF_BYTES_OUT == 16'h0000)
		else $error("reserved format gave a size");
	a_zero_wait: assert property (PSEL_IN && PENABLE_IN |-> PREADY_OUT)
		else $error("access phase not ready");
	a_map_ok: assert property (PSEL_IN && PENABLE_IN && PADDR_IN == 12'h100 |-> !PSLVERR_OUT)
		else $error("error on mapped address");
	c_strip: cover property (vv && STRIP_CRC_OUT);
	c_thresh: cover property (FREE_DESC_THRESHOLD_OUT);
	c_slverr: cover property (PSLVERR_OUT);
endmodule // rx_cfg_properties
`default_nettype wire

// File: verif/rx_phy_model.sv
// Receive path model: frame start, then end with attributes valid only then
`timescale 1ns/1ns
`default_nettype none
module rx_phy_model #(
	parameter int GAP = 6
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic go_in,
	input wire logic [100:0] attr_in,
	output logic start_out,
	output logic end_out,
	output logic [100:0] attr_out
);
	logic [7:0] cnt_ff;
	logic [100:0] held_ff;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_ff <= 8'h00;
			start_out <= 1'b0;
			end_out <= 1'b0;
			held_ff <= '0;
		end else begin
			start_out <= go_in;
			end_out <= cnt_ff == 8'h01;
			cnt_ff <= go_in ? 8'(GAP) : (cnt_ff != 8'h00 ? cnt_ff - 8'h01 : 8'h00);
			if (go_in) begin
				held_ff <= attr_in;
			end
		end
	end
	// Inverse outside the end cycle, so stale attributes never pass by luck
	assign attr_out = end_out ? held_ff : ~held_ff;
endmodule // rx_phy_model
`default_nettype wire

// File: verif/tb_rx_control_filter_config.sv
// Testbench: register access, frame verdicts and descriptor threshold
`timescale 1ns/1ns
`default_nettype none
module tb_rx_control_filter_config;
	localparam logic [47:0] UNI = 48'h0123_4567_89ab;
	localparam logic [47:0] BC = 48'hffff_ffff_ffff;
	localparam logic [47:0] ST = 48'h0200_0000_0001;
	localparam logic [47:0] MC = 48'h0180_c200_0001;
	logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, go = 1'b0;
	logic [11:0] padr = 12'h000;
	logic [31:0] pwd = 32'h0, prd, rd;
	logic [100:0] pa = '0, fa;
	logic [15:0] free = 16'h0000, ring = 16'h0040, bb, dl;
	logic [15:0] bsz [8] = '{16'h0800, 16'h0400, 16'h0200, 16'h0100,
		16'h0000, 16'h4000, 16'h2000, 16'h1000};
	int hs [4] = '{36, 35, 34, 32};
	logic [11:0] hi;
	logic [1:0] fmt;
	logic [2:0] n;
	logic prdy, perr, se, fst, fen, vv, acc, sc, thr;
	int err_total = 0;
	int comparisons = 0;
	always #20 clk = ~clk;
	rx_control_filter_config rx_control_filter_config_i (.CLK_IN(clk), .RESET_N_IN(rst_n),
		.PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(padr), .PWDATA_IN(pwd),
		.PRDATA_OUT(prd), .PREADY_OUT(prdy), .PSLVERR_OUT(perr), .FRAME_START_IN(fst),
		.FRAME_END_IN(fen), .DEST_ADDR_IN(fa[100:53]), .FILTER_MATCH_IN(fa[52]),
		.STATION_MATCH_IN(fa[51]), .VLAN_TAGGED_IN(fa[50]), .VLAN_TABLE_HIT_IN(fa[49]),
		.CFI_IN(fa[48]), .ETHERTYPE_IN(fa[47:32]), .OPCODE_IN(fa[31:16]), .FRAME_LEN_IN(fa[15:0]),
		.PSPLIT_BUF_BYTES_IN(16'h0500), .RING_DESC_COUNT_IN(ring), .FREE_DESC_COUNT_IN(free),
		.VERDICT_VALID_OUT(vv), .ACCEPT_OUT(acc), .BUF_BYTES_OUT(bb), .DESC_LEN_OUT(dl),
		.HASH_INDEX_OUT(hi), .STRIP_CRC_OUT(sc), .DESCRIPTOR_FORMAT_OUT(fmt),
		.FREE_DESC_THRESHOLD_OUT(thr));
	rx_phy_model rx_phy_model_i (.clk_in(clk), .rst_n_in(rst_n), .go_in(go), .attr_in(pa),
		.start_out(fst), .end_out(fen), .attr_out(fa));
	task chk(input logic [47:0] got, input logic [47:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task finish_test;
		$display("Checks %0d, mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		padr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (prdy !== 1'b1 && k < 16);
		if (prdy !== 1'b1) begin
			err_total++;
			finish_test;
		end
		rd = prd;
		se = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task wr(input logic [31:0] d);
		apb(1'b1, 12'h100, d);
	endtask
	task fbeg(input logic [47:0] d, input logic [4:0] f, input logic [15:0] t,
		input logic [15:0] o, input logic [15:0] l);
		@(posedge clk);
		pa <= {d, f, t, o, l};
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
	endtask
	task fend(input logic e);
		int k;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (vv !== 1'b1 && k < 32);
		if (vv !== 1'b1) begin
			err_total++;
			finish_test;
		end
		chk(acc, e);
	endtask
	task fr(input logic [47:0] d, input logic [4:0] f, input logic [15:0] t,
		input logic [15:0] o, input logic [15:0] l, input logic e);
		fbeg(d, f, t, o, l);
		fend(e);
	endtask
	task fp(input logic [47:0] d, input logic [4:0] f, input logic [15:0] l, input logic e);
		fr(d, f, 16'h0800, 16'h0000, l, e);
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b0, 12'h100, 32'h0);
		chk(rd, 32'h0);
		wr(32'h7edf_ffff);
		apb(1'b0, 12'h100, 32'h0);
		chk(rd, 32'h7edf_bf20);
		apb(1'b0, 12'h108, 32'h0);
		chk(se, 1'b1);
		chk(rd, 32'h0);
		for (int i = 0; i < 8; i++) begin
			if (i != 4) begin
				wr({6'h0, i[2], 7'h0, i[1:0], 16'h0});
				fp(UNI, 5'h10, 16'h0040, 1'b1);
				chk(bb, bsz[i]);
			end
		end
		wr(32'h1a01_0000);
		fp(UNI, 5'h10, 16'h0040, 1'b1);
		chk(bb, 16'h0c00);
		for (int j = 1; j < 3; j++) begin
			wr({20'h0, j[1:0], 10'h0});
			fp(UNI, 5'h10, 16'h0040, 1'b1);
			chk(bb, j == 1 ? 16'h0500 : 16'h0000);
			chk(fmt, j[1:0]);
		end
		for (int m = 0; m < 4; m++) begin
			wr({18'h0, m[1:0], 12'h0});
			fp(UNI, 5'h10, 16'h0040, 1'b1);
			chk(hi, (UNI >> hs[m]) & 48'hfff);
		end
		wr(32'h0400_0000);
		fp(UNI, 5'h10, 16'h0064, 1'b1);
		chk(dl, 16'h0060);
		chk(sc, 1'b1);
		wr(32'h0);
		fp(UNI, 5'h10, 16'h0064, 1'b1);
		chk(dl, 16'h0064);
		fp(BC, 5'h00, 16'h0040, 1'b0);
		fp(UNI, 5'h10, 16'h05f3, 1'b0);
		fp(UNI, 5'h10, 16'h05f2, 1'b1);
		wr(32'h0000_0020);
		fp(UNI, 5'h10, 16'h05f3, 1'b1);
		wr(32'h0000_8000);
		fp(BC, 5'h00, 16'h0040, 1'b1);
		wr(32'h0004_0000);
		fp(UNI, 5'h14, 16'h0040, 1'b0);
		fp(UNI, 5'h16, 16'h0040, 1'b1);
		wr(32'h0018_0000);
		fp(UNI, 5'h14, 16'h0040, 1'b0);
		fp(UNI, 5'h15, 16'h0040, 1'b1);
		wr(32'h0);
		fp(UNI, 5'h14, 16'h0040, 1'b1);
		wr(32'h0040_0000);
		fr(ST, 5'h18, 16'h8808, 16'h0001, 16'h0040, 1'b0);
		wr(32'h0);
		fr(ST, 5'h18, 16'h8808, 16'h0001, 16'h0040, 1'b1);
		fr(MC, 5'h00, 16'h8808, 16'h0002, 16'h0040, 1'b0);
		wr(32'h0080_0000);
		fr(MC, 5'h00, 16'h8808, 16'h0002, 16'h0040, 1'b1);
		fr(UNI, 5'h10, 16'h8808, 16'h0002, 16'h0040, 1'b0);
		wr(32'h0000_8000);
		fbeg(BC, 5'h00, 16'h0800, 16'h0000, 16'h0040);
		wr(32'h0);
		fend(1'b1);
		fp(BC, 5'h00, 16'h0040, 1'b0);
		// Status: 25 accepted, 8 dropped, last verdict a drop
		apb(1'b0, 12'h104, 32'h0);
		chk(rd, 32'h0008_1900);
		chk(se, 1'b0);
		for (int c = 0; c < 4; c++) begin
			wr({22'h0, c[1:0], 8'h0});
			@(posedge clk);
			free <= c < 3 ? 16'h0040 >> (c + 1) : 16'h0008;
			n = 3'h0;
			repeat (4) begin
				@(posedge clk);
				n = n + {2'h0, thr};
			end
			chk(n, c < 3);
			free <= 16'h0000;
		end
		// Empty ring: zero free equals every fraction yet must not fire
		wr(32'h0);
		ring <= 16'h0000;
		n = 3'h0;
		repeat (4) begin
			@(posedge clk);
			n = n + {2'h0, thr};
		end
		chk(n, 3'h0);
		finish_test;
	end
endmodule // tb_rx_control_filter_config
bind rx_control_filter_config rx_cfg_properties rx_cfg_properties_i (.*);
`default_nettype wire
